// [rtl/twg_telemetry_write_guard.sv]
`timescale 1ns/1ps
module twg_telemetry_write_guard #(
	parameter int INIT_CYCLES  = twg_pkg::INIT_CYC,
	parameter int HB_DIV       = 32,
	parameter int SYNC_HALF    = 2,
	parameter int SYNC_LOST    = 16,
	parameter int MARGIN_TICKS = 64
) (
	// clock and reset
	input  wire logic                                     mclk,
	input  wire logic                                     rst_n,
	// wishbone slave
	input  wire logic                                     wb_cyc_i,
	input  wire logic                                     wb_stb_i,
	input  wire logic                                     wb_we_i,
	input  wire logic [6:0]                               wb_adr_i,
	input  wire logic [3:0]                               wb_sel_i,
	input  wire logic [31:0]                              wb_dat_i,
	output logic [31:0]                                   wb_dat_o,
	output logic                                          wb_ack_o,
	// telemetry samples
	input  wire twg_pkg::twg_meas_t [twg_pkg::NCH-1:0]    meas,
	input  wire logic [15:0]                              vinSample,
	input  wire logic signed [15:0]                       dieTemp,
	input  wire logic                                     faultLogReq,
	// pins
	input  wire logic                                     wpPin,
	input  wire logic [3:0]                               addrStrap,
	input  wire logic [twg_pkg::NCH-1:0]                  runIn,
	input  wire logic                                     heartbeatIn,
	output logic                                          heartbeatOut,
	output logic                                          heartbeatOe,
	input  wire logic                                     syncIn,
	output logic                                          syncOut,
	output logic                                          syncOe,
	// control outputs
	output twg_pkg::twg_ee_t                              eeCmd,
	output logic [6:0]                                    slaveAddr,
	output logic [twg_pkg::NCH-1:0][twg_pkg::RAMP_W-1:0]  rampLevel,
	output logic                                          marginBusy,
	output logic                                          phaseStart,
	output logic                                          initBusy
);
	localparam int IW = $clog2(INIT_CYCLES + 1);
	localparam int HW = $clog2(HB_DIV);
	localparam int SW = $clog2(SYNC_LOST + 1);
	localparam int YW = $clog2(SYNC_HALF + 1);
	localparam int MW = $clog2(MARGIN_TICKS + 1);
	// heartbeat bit idles high on its pull-up, so no false edge after reset
	localparam logic [8:0] PIN_IDLE = 9'h008;

	// refuse parameter values the counters cannot serve
	generate
		if (HB_DIV < 2 || SYNC_HALF < 1 || SYNC_LOST < 2 || MARGIN_TICKS < 1 || INIT_CYCLES < 1)
		begin : gBadParam
			$error("twg: parameter out of range");
		end
	endgenerate

	// registers and state
	logic [7:0]        page_q, oper_q, wp_q, unlock_q;
	logic [7:0]        pwm_q [twg_pkg::NCH];
	logic [15:0]       ofs_q [twg_pkg::NCH];
	logic [15:0]       iout_q [twg_pkg::NCH];
	logic [15:0]       iin_q [twg_pkg::NCH];
	logic [15:0]       tRd_q [twg_pkg::NCH];
	logic [15:0]       tPk_q [twg_pkg::NCH];
	logic [15:0]       vin_q, vinPk_q;
	logic              cml_q, eeBlk_q, lowF_q, wbAck_q, odLow_q;
	logic [31:0]       wbDat_q, rdData;
	logic [IW-1:0]     initCnt_q;
	logic [HW-1:0]     hbCnt_q;
	logic [SW-1:0]     syncAge_q;
	logic [YW-1:0]     syncHalf_q;
	logic [MW-1:0]     marginCnt_q;
	logic              syncLow_q, hbOe_q, phase_q, initBusy_q, marginBusy_q;
	logic [6:0]        slaveAddr_q;
	logic [twg_pkg::RAMP_W-1:0] ramp_q [twg_pkg::NCH];
	twg_pkg::twg_ee_t  ee_q;
	logic [8:0]        pinS1_q, pinS2_q;
	logic              hbS3_q, syncS3_q;
	logic [twg_pkg::NCH-1:0] runS3_q;

	// decoded bus and pin signals
	logic [4:0]        idx;
	logic              ch, wbReq, wbWr, wrOk, wrBad, clrPk, storeReq, wpS, hbTick, syncRise, syncEst;
	logic [3:0]        strapS;
	logic [twg_pkg::NCH-1:0] runS, runRise;
	logic [7:0]        statusVal;

	// registers a write can reach at all
	function automatic logic twg_writable(input logic [4:0] i);
		return i inside {twg_pkg::IDX_PAGE, twg_pkg::IDX_OPER, twg_pkg::IDX_CLRF, twg_pkg::IDX_WPREG,
			twg_pkg::IDX_STATUS, twg_pkg::IDX_PWM, twg_pkg::IDX_IINOFS, twg_pkg::IDX_CLRPK,
			twg_pkg::IDX_UNLOCK, twg_pkg::IDX_STORE};
	endfunction

	// write gate from protect pin and protect register
	function automatic logic twg_write_ok(input logic [4:0] i, input logic pin, input logic [7:0] wpr);
		logic pinOk;
		logic regOk;
		pinOk = !pin || (i inside {twg_pkg::IDX_PAGE, twg_pkg::IDX_OPER, twg_pkg::IDX_CLRF,
			twg_pkg::IDX_CLRPK, twg_pkg::IDX_UNLOCK, twg_pkg::IDX_STATUS});
		if (wpr[twg_pkg::WP_ALL_BIT])
			regOk = (i == twg_pkg::IDX_WPREG);
		else if (wpr[twg_pkg::WP_CTRL_BIT])
			regOk = i inside {twg_pkg::IDX_WPREG, twg_pkg::IDX_PAGE, twg_pkg::IDX_OPER};
		else
			regOk = 1'b1;
		return twg_writable(i) && pinOk && regOk;
	endfunction

	// pin synchronisers, edges taken from the second stage onward
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pinS1_q  <= PIN_IDLE;
			pinS2_q  <= PIN_IDLE;
			hbS3_q   <= 1'b1;
			syncS3_q <= 1'b0;
			runS3_q  <= '0;
		end
		else
		begin
			pinS1_q  <= {wpPin, addrStrap, heartbeatIn, syncIn, runIn};
			pinS2_q  <= pinS1_q;
			hbS3_q   <= pinS2_q[3];
			syncS3_q <= pinS2_q[2];
			runS3_q  <= runS;
		end
	end

	assign wpS      = pinS2_q[8];
	assign strapS   = pinS2_q[7:4];
	assign runS     = pinS2_q[1:0];
	assign hbTick   = pinS2_q[3] & ~hbS3_q;
	assign syncRise = pinS2_q[2] & ~syncS3_q;
	assign runRise  = runS & ~runS3_q;
	assign syncEst  = (syncAge_q < SW'(SYNC_LOST));

	// bus decode, one request per ack
	assign idx      = wb_adr_i[6:2];
	assign ch       = page_q[0];
	assign wbReq    = wb_cyc_i & wb_stb_i & ~wbAck_q;
	assign wbWr     = wbReq & wb_we_i & wb_sel_i[0];
	assign wrOk     = wbWr & twg_write_ok(idx, wpS, wp_q);
	assign wrBad    = wbWr & twg_writable(idx) & ~twg_write_ok(idx, wpS, wp_q);
	assign clrPk    = wrOk & (idx == twg_pkg::IDX_CLRPK);
	assign storeReq = wrOk & (idx == twg_pkg::IDX_STORE);

	assign statusVal = {3'h0, initBusy_q, (pwm_q[ch][1:0] == twg_pkg::PWM_FCM), lowF_q, eeBlk_q, cml_q};

	// read mux
	always_comb
	begin
		rdData = 32'h0000_0000;
		case (idx)
			twg_pkg::IDX_PAGE:   rdData[7:0]  = page_q;
			twg_pkg::IDX_OPER:   rdData[7:0]  = oper_q;
			twg_pkg::IDX_WPREG:  rdData[7:0]  = wp_q;
			twg_pkg::IDX_STATUS: rdData[7:0]  = statusVal;
			twg_pkg::IDX_PWM:    rdData[7:0]  = pwm_q[ch];
			twg_pkg::IDX_IINOFS: rdData[15:0] = ofs_q[ch];
			twg_pkg::IDX_IOUT:   rdData[15:0] = iout_q[ch];
			twg_pkg::IDX_TEMP:   rdData[15:0] = tRd_q[ch];
			twg_pkg::IDX_TPEAK:  rdData[15:0] = tPk_q[ch];
			twg_pkg::IDX_IIN:    rdData[15:0] = iin_q[ch];
			twg_pkg::IDX_VIN:    rdData[15:0] = vin_q;
			twg_pkg::IDX_VPEAK:  rdData[15:0] = vinPk_q;
			twg_pkg::IDX_SADDR:  rdData[6:0]  = slaveAddr_q;
			default:             rdData = 32'h0000_0000;
		endcase
	end

	// bus answer, one cycle after the request
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wbAck_q <= 1'b0;
			wbDat_q <= 32'h0000_0000;
		end
		else
		begin
			wbAck_q <= wbReq;
			if (wbReq && !wb_we_i)
				wbDat_q <= rdData;
		end
	end

	// control registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			page_q   <= twg_pkg::PAGE_RST;
			oper_q   <= twg_pkg::OPER_RST;
			wp_q     <= twg_pkg::WPREG_RST;
			unlock_q <= 8'h00;
			for (int c = 0; c < twg_pkg::NCH; c++)
			begin
				pwm_q[c] <= twg_pkg::PWM_RST;
				ofs_q[c] <= twg_pkg::IIN_OFS_RST;
			end
		end
		else if (wrOk)
		begin
			unique case (idx)
				twg_pkg::IDX_PAGE:   page_q   <= wb_dat_i[7:0];
				twg_pkg::IDX_OPER:   oper_q   <= wb_dat_i[7:0];
				twg_pkg::IDX_WPREG:  wp_q     <= wb_dat_i[7:0];
				twg_pkg::IDX_UNLOCK: unlock_q <= wb_dat_i[7:0];
				twg_pkg::IDX_STORE:  unlock_q <= 8'h00;
				twg_pkg::IDX_PWM:    pwm_q[ch] <= wb_dat_i[7:0];
				twg_pkg::IDX_IINOFS:
				begin
					ofs_q[ch][7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						ofs_q[ch][15:8] <= wb_dat_i[15:8];
				end
				default: ;
			endcase
		end
	end

	// comm fault flag, a new fault wins over clearing
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			cml_q <= 1'b0;
		else if (wrBad || (storeReq && (unlock_q != twg_pkg::EE_UNLOCK_KEY || eeBlk_q || initBusy_q)))
			cml_q <= 1'b1;
		else if (wrOk && idx == twg_pkg::IDX_STATUS && wb_dat_i[twg_pkg::ST_CML])
			cml_q <= 1'b0;
		else if (wrOk && idx == twg_pkg::IDX_CLRF)
			cml_q <= 1'b0;
	end

	// thermal gate on eeprom writes with hysteresis
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			eeBlk_q <= 1'b0;
		else if (dieTemp > twg_pkg::EE_BLOCK_C)
			eeBlk_q <= 1'b1;
		else if (dieTemp < twg_pkg::EE_ALLOW_C)
			eeBlk_q <= 1'b0;
	end

	// eeprom requests, fault log first
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ee_q <= '0;
		else
		begin
			ee_q.req      <= 1'b0;
			ee_q.faultLog <= 1'b0;
			if (faultLogReq && !eeBlk_q && !initBusy_q)
			begin
				ee_q.req      <= 1'b1;
				ee_q.faultLog <= 1'b1;
			end
			else if (storeReq && unlock_q == twg_pkg::EE_UNLOCK_KEY && !eeBlk_q && !initBusy_q)
				ee_q.req <= 1'b1;
		end
	end

	// initialization window and strap capture
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			initCnt_q   <= '0;
			initBusy_q  <= 1'b1;
			slaveAddr_q <= twg_pkg::SADDR_DFLT;
		end
		else if (initBusy_q)
		begin
			initCnt_q <= initCnt_q + 1'b1;
			if (initCnt_q == IW'(INIT_CYCLES - 1))
			begin
				initBusy_q  <= 1'b0;
				slaveAddr_q <= {twg_pkg::SADDR_DFLT[6:4], strapS};
			end
		end
	end

	// own heartbeat drive, open drain low half
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hbCnt_q <= '0;
			hbOe_q  <= 1'b0;
			odLow_q <= 1'b0;
		end
		else
		begin
			odLow_q <= 1'b0;
			hbCnt_q <= (hbCnt_q == HW'(HB_DIV - 1)) ? '0 : hbCnt_q + 1'b1;
			hbOe_q  <= (hbCnt_q < HW'(HB_DIV / 2));
		end
	end

	// sync drive and phase lock
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncHalf_q <= '0;
			syncLow_q  <= 1'b0;
			syncAge_q  <= SW'(SYNC_LOST);
			phase_q    <= 1'b0;
			lowF_q     <= 1'b0;
		end
		else
		begin
			if (hbTick)
			begin
				syncHalf_q <= (syncHalf_q == YW'(SYNC_HALF - 1)) ? '0 : syncHalf_q + 1'b1;
				if (syncHalf_q == YW'(SYNC_HALF - 1))
					syncLow_q <= ~syncLow_q;
			end
			if (syncRise)
				syncAge_q <= '0;
			else if (hbTick && syncEst)
				syncAge_q <= syncAge_q + 1'b1;
			phase_q <= syncRise & ~initBusy_q;
			if (|runRise && !syncEst)
				lowF_q <= 1'b1;
			else if (syncEst)
				lowF_q <= 1'b0;
		end
	end

	// margin transition timer
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			marginCnt_q  <= '0;
			marginBusy_q <= 1'b0;
		end
		else if (wrOk && idx == twg_pkg::IDX_OPER)
		begin
			marginCnt_q  <= MW'(MARGIN_TICKS);
			marginBusy_q <= 1'b1;
		end
		else if (hbTick && marginBusy_q)
		begin
			marginCnt_q <= marginCnt_q - 1'b1;
			if (marginCnt_q == MW'(1))
				marginBusy_q <= 1'b0;
		end
	end

	// input voltage and its peak
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			vin_q   <= 16'h0000;
			vinPk_q <= 16'h0000;
		end
		else
		begin
			vin_q <= vinSample;
			if (clrPk)
				vinPk_q <= 16'h0000;
			else if (vinSample > vinPk_q)
				vinPk_q <= vinSample;
		end
	end

	// per channel telemetry and ramp
	generate
		for (genvar c = 0; c < twg_pkg::NCH; c++)
		begin : gCh
			logic signed [15:0] tSel;
			logic signed [16:0] dT;
			logic signed [33:0] pA;
			logic signed [43:0] pB;
			logic signed [44:0] diff;
			logic [23:0]        pI;
			logic [17:0]        iinSum;

			assign tSel   = (c == 1 && pwm_q[0][twg_pkg::PWM_TSEL_BIT]) ? meas[0].temp : meas[c].temp;
			assign dT     = {tSel[15], tSel} - twg_pkg::T_REF_C;
			assign pA     = $signed({1'b0, meas[c].iRaw}) * dT;
			assign pB     = pA * twg_pkg::TC_Q16;
			assign diff   = $signed({29'h0, meas[c].iRaw}) - (pB >>> 16);
			assign pI     = meas[c].duty * iout_q[c];
			assign iinSum = {1'b0, pI[23:7]} + {2'h0, ofs_q[c]};

			always_ff @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					iout_q[c] <= 16'h0000;
					iin_q[c]  <= 16'h0000;
					tRd_q[c]  <= 16'h0000;
					tPk_q[c]  <= twg_pkg::PK_T_MIN;
				end
				else
				begin
					iout_q[c] <= diff[44] ? 16'h0000 : (|diff[43:16]) ? 16'hffff : diff[15:0];
					iin_q[c]  <= (|iinSum[17:16]) ? 16'hffff : iinSum[15:0];
					// each channel reports its own sensor; the channel 0 sensor only feeds the channel 1 correction
					tRd_q[c]  <= meas[c].temp;
					if (clrPk)
						tPk_q[c] <= twg_pkg::PK_T_MIN;
					else if (meas[c].temp > $signed(tPk_q[c]))
						tPk_q[c] <= meas[c].temp;
				end
			end

			// output ramp stepped by heartbeat ticks
			always_ff @(posedge mclk or negedge rst_n)
			begin
				if (!rst_n)
					ramp_q[c] <= '0;
				else if (!runS[c] || initBusy_q)
					ramp_q[c] <= '0;
				else if (hbTick && ramp_q[c] != '1)
					ramp_q[c] <= ramp_q[c] + 1'b1;
			end

			assign rampLevel[c] = ramp_q[c];
		end
	endgenerate

	// outputs straight from flops, syncOe the OR of initBusy_q and syncLow_q
	assign wb_dat_o     = wbDat_q;
	assign wb_ack_o     = wbAck_q;
	assign heartbeatOut = odLow_q;
	assign heartbeatOe  = hbOe_q;
	assign syncOut      = odLow_q;
	assign syncOe       = initBusy_q | syncLow_q;
	assign eeCmd        = ee_q;
	assign slaveAddr    = slaveAddr_q;
	assign marginBusy   = marginBusy_q;
	assign phaseStart   = phase_q;
	assign initBusy     = initBusy_q;
endmodule

// [rtl/twg_pkg.sv]
package twg_pkg;
	// channel count and register indices (byte address = index * 4)
	localparam int NCH = 2;
	localparam logic [4:0] IDX_PAGE = 5'h00;
	localparam logic [4:0] IDX_OPER = 5'h01;
	localparam logic [4:0] IDX_CLRF = 5'h02;
	localparam logic [4:0] IDX_WPREG = 5'h03;
	localparam logic [4:0] IDX_STATUS = 5'h04;
	localparam logic [4:0] IDX_PWM = 5'h05;
	localparam logic [4:0] IDX_IINOFS = 5'h06;
	localparam logic [4:0] IDX_IOUT = 5'h07;
	localparam logic [4:0] IDX_TEMP = 5'h08;
	localparam logic [4:0] IDX_TPEAK = 5'h09;
	localparam logic [4:0] IDX_IIN = 5'h0a;
	localparam logic [4:0] IDX_VIN = 5'h0b;
	localparam logic [4:0] IDX_VPEAK = 5'h0c;
	localparam logic [4:0] IDX_CLRPK = 5'h0d;
	localparam logic [4:0] IDX_UNLOCK = 5'h0e;
	localparam logic [4:0] IDX_SADDR = 5'h0f;
	localparam logic [4:0] IDX_STORE = 5'h10;
	// reset values
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [7:0] OPER_RST = 8'h80;
	localparam logic [7:0] WPREG_RST = 8'h00;
	localparam logic [7:0] PWM_RST = 8'h00;
	localparam logic [15:0] IIN_OFS_RST = 16'h003d; // 30.5 mA at 0.5 mA per lsb
	localparam logic [6:0] SADDR_DFLT = 7'h4f;
	localparam logic [7:0] EE_UNLOCK_KEY = 8'h2b;
	localparam logic signed [15:0] PK_T_MIN = 16'sh8000;
	// field positions
	localparam int PWM_TSEL_BIT = 4;
	localparam logic [1:0] PWM_FCM = 2'h2;
	localparam int WP_ALL_BIT = 7;
	localparam int WP_CTRL_BIT = 6;
	localparam int ST_CML = 0;
	localparam int ST_EEBLK = 1;
	localparam int ST_LOWF = 2;
	localparam int ST_IINOK = 3;
	localparam int ST_INIT = 4;
	// temperature correction and thermal limits
	localparam int TC_PPM = 3900;
	localparam logic signed [9:0] TC_Q16 = 10'(TC_PPM * 65536 / 1000000);
	localparam logic signed [16:0] T_REF_C = 17'sh00019;
	localparam logic signed [15:0] EE_BLOCK_C = 16'sh0082;
	localparam logic signed [15:0] EE_ALLOW_C = 16'sh007d;
	// timing
	localparam int MCLK_KHZ = 250000;
	localparam int INIT_MS = 50;
	localparam int INIT_CYC = INIT_MS * MCLK_KHZ;
	localparam int RAMP_W = 8;
	// telemetry sample per channel and eeprom request
	typedef struct packed {
		logic [15:0]        iRaw;
		logic signed [15:0] temp;
		logic [7:0]         duty;
	} twg_meas_t;
	typedef struct packed {
		logic req;
		logic faultLog;
	} twg_ee_t;
endpackage

// [verif/twg_guard_monitor.sv]
`timescale 1ns/1ps
module twg_guard_monitor #(
	parameter int INIT_CYCLES = 20
) (
	// clock and reset
	input wire logic                                     mclk,
	input wire logic                                     rst_n,
	// bus
	input wire logic                                     wb_cyc_i,
	input wire logic                                     wb_stb_i,
	input wire logic                                     wb_ack_o,
	// sensed inputs
	input wire logic signed [15:0]                       dieTemp,
	input wire logic                                     faultLogReq,
	input wire logic [3:0]                               addrStrap,
	// outputs
	input wire logic                                     heartbeatOut,
	input wire logic                                     syncOut,
	input wire logic                                     syncOe,
	input wire twg_pkg::twg_ee_t                         eeCmd,
	input wire logic [6:0]                               slaveAddr,
	input wire logic [twg_pkg::NCH-1:0][twg_pkg::RAMP_W-1:0] rampLevel,
	input wire logic                                     phaseStart,
	input wire logic                                     initBusy
);
	int cycCnt_q;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// cycles since reset, saturating
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			cycCnt_q <= 0;
		else if (cycCnt_q < INIT_CYCLES + 4)
			cycCnt_q <= cycCnt_q + 1;
	end
	// request taken, die hot, die cool
	sequence s_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_hot;
		(dieTemp > twg_pkg::EE_BLOCK_C)[*3];
	endsequence
	sequence s_cool;
		(dieTemp < twg_pkg::EE_ALLOW_C)[*3];
	endsequence
	a_read_served: assert property (s_taken |=> wb_ack_o)
		else $error("request not answered");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_init_len: assert property (((cycCnt_q < INIT_CYCLES - 1) |-> initBusy)
		and ((cycCnt_q > INIT_CYCLES + 1) |-> !initBusy))
		else $error("init length wrong");
	a_init_addr: assert property (initBusy |-> slaveAddr == twg_pkg::SADDR_DFLT)
		else $error("address not default in init");
	a_strap_addr: assert property ($fell(initBusy) |-> ##3 slaveAddr == {3'b100, addrStrap})
		else $error("strap not applied");
	a_init_sync: assert property (initBusy |-> syncOe && !syncOut)
		else $error("sync not held low in init");
	a_init_quiet: assert property (initBusy |-> rampLevel == '0 && !phaseStart)
		else $error("ramp or phase active in init");
	a_open_drain: assert property (heartbeatOut == 1'b0 && syncOut == 1'b0)
		else $error("open drain pin driven high");
	a_ee_hot: assert property (s_hot |-> !(eeCmd.req && !eeCmd.faultLog))
		else $error("store while hot");
	a_flog_req: assert property (s_cool ##0 (faultLogReq && !initBusy)
		|-> ##[1:2] (eeCmd.req && eeCmd.faultLog))
		else $error("fault log request lost");
	a_flog_only: assert property (eeCmd.req && eeCmd.faultLog
		|-> $past(faultLogReq) || $past(faultLogReq, 2))
		else $error("fault log write without request");
endmodule

bind twg_telemetry_write_guard twg_guard_monitor #(.INIT_CYCLES(INIT_CYCLES)) i_twg_guard_monitor (
	.mclk(mclk),
	.rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.dieTemp(dieTemp),
	.faultLogReq(faultLogReq),
	.addrStrap(addrStrap),
	.heartbeatOut(heartbeatOut),
	.syncOut(syncOut),
	.syncOe(syncOe),
	.eeCmd(eeCmd),
	.slaveAddr(slaveAddr),
	.rampLevel(rampLevel),
	.phaseStart(phaseStart),
	.initBusy(initBusy)
);

// [verif/twg_board_model.sv]
`timescale 1ns/1ps
module twg_board_model (
	// device pin drives
	input wire logic heartbeatOut,
	input wire logic heartbeatOe,
	input wire logic syncOut,
	input wire logic syncOe,
	// bench control
	input wire logic syncEn,
	// resolved lines
	output logic     heartbeatLine,
	output logic     syncLine
);
	logic extClk = 1'b0;
	logic sibLow = 1'b0;
	// hard clock, stands still low when stopped
	initial
	begin
		forever #62.5 extClk = syncEn ? ~extClk : 1'b0;
	end
	// slower sibling sharing the heartbeat
	initial
	begin
		forever #300 sibLow = ~sibLow;
	end
	assign heartbeatLine = !(heartbeatOe && !heartbeatOut) && !sibLow;
	assign syncLine = (syncOe && !syncOut) ? 1'b0 : extClk;
endmodule

// [verif/twg_telemetry_write_guard_tb_top.sv]
`timescale 1ns/1ps
module twg_telemetry_write_guard_tb_top;
	logic                          mclk = 1'b0;
	logic                          rst_n, cyc, stb, we, ack, faultLogReq, wpPin, syncEn;
	logic                          hbOut, hbOe, hbLine, syncOut, syncOe, syncLine;
	logic                          marginBusy, phaseStart, initBusy;
	logic [6:0]                    adr, slaveAddr;
	logic [3:0]                    sel;
	logic [31:0]                   dIn, dOut, q;
	logic [1:0]                    runIn;
	logic [15:0]                   vinSample;
	logic signed [15:0]            dieTemp;
	logic [1:0][7:0]               ramp;
	twg_pkg::twg_meas_t [1:0]      meas;
	twg_pkg::twg_ee_t              eeCmd;
	logic                          eeFl;
	int                            badCount, checked, eeN, psN, n;
	// clock
	initial
	begin
		forever #2 mclk = ~mclk;
	end
	twg_telemetry_write_guard #(.INIT_CYCLES(20), .MARGIN_TICKS(4)) i_twg_telemetry_write_guard (
		.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dIn), .wb_dat_o(dOut), .wb_ack_o(ack), .meas(meas),
		.vinSample(vinSample), .dieTemp(dieTemp), .faultLogReq(faultLogReq), .wpPin(wpPin),
		.addrStrap(4'h5), .runIn(runIn), .heartbeatIn(hbLine), .heartbeatOut(hbOut),
		.heartbeatOe(hbOe), .syncIn(syncLine), .syncOut(syncOut), .syncOe(syncOe), .eeCmd(eeCmd),
		.slaveAddr(slaveAddr), .rampLevel(ramp), .marginBusy(marginBusy), .phaseStart(phaseStart),
		.initBusy(initBusy));
	twg_board_model i_twg_board_model (.heartbeatOut(hbOut), .heartbeatOe(hbOe), .syncOut(syncOut),
		.syncOe(syncOe), .syncEn(syncEn), .heartbeatLine(hbLine), .syncLine(syncLine));
	// count eeprom requests and phase starts
	always @(posedge mclk)
	begin
		if (eeCmd.req === 1'b1)
		begin
			eeN++;
			eeFl = eeCmd.faultLog;
		end
		if (phaseStart === 1'b1)
			psN++;
	end
	task automatic report_and_stop;
		if (badCount == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			badCount++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
	endtask
	// one classic cycle, held until ack
	task automatic bus(input logic [4:0] i, input logic w, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		sel <= s;
		dIn <= d;
		k = 0;
		do
		begin
			@(posedge mclk);
			k++;
		end
		while (ack !== 1'b1 && k < 40);
		q = dOut;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1)
		begin
			badCount++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [4:0] i, input logic [31:0] d);
		bus(i, 1'b1, d, 4'h1);
	endtask
	task automatic rd(input string nm, input logic [4:0] i, input logic [31:0] e);
		bus(i, 1'b0, 32'h0, 4'hf);
		chk(nm, e, q);
	endtask
	task automatic st(input string nm, input int b, input logic e);
		bus(twg_pkg::IDX_STATUS, 1'b0, 32'h0, 4'hf);
		chk(nm, {31'h0, e}, {31'h0, q[b]});
	endtask
	function automatic int iexp(input int r, input int t);
		return r - ((r * (t - 25) * int'(twg_pkg::TC_Q16)) >>> 16);
	endfunction
	task automatic sc_defaults;
		rd("page", twg_pkg::IDX_PAGE, 32'h0);
		rd("oper", twg_pkg::IDX_OPER, 32'h80);
		rd("wprot", twg_pkg::IDX_WPREG, 32'h0);
		for (int p = 1; p >= 0; p--)
		begin
			wr(twg_pkg::IDX_PAGE, 32'(p));
			rd("pwm", twg_pkg::IDX_PWM, 32'h0);
			rd("ofs", twg_pkg::IDX_IINOFS, 32'h3d);
		end
		rd("unmapped", 5'h1f, 32'h0);
		rd("saddr", twg_pkg::IDX_SADDR, 32'h45);
		chk("saddr pin", 32'h45, {25'h0, slaveAddr});
	endtask
	task automatic sc_pin;
		@(posedge mclk) wpPin <= 1'b1;
		step(4);
		wr(twg_pkg::IDX_PWM, 32'h12);
		rd("pwm wp", twg_pkg::IDX_PWM, 32'h0);
		st("cml", 0, 1'b1);
		wr(twg_pkg::IDX_CLRF, 32'h0);
		st("cml clr", 0, 1'b0);
		wr(twg_pkg::IDX_PWM, 32'h12);
		wr(twg_pkg::IDX_STATUS, 32'h1);
		st("cml w1c", 0, 1'b0);
		wr(twg_pkg::IDX_OPER, 32'h40);
		step(2);
		chk("margin", 32'h1, {31'h0, marginBusy});
		rd("oper wp", twg_pkg::IDX_OPER, 32'h40);
		for (n = 0; n < 2000 && marginBusy !== 1'b0; n++)
			step(1);
		chk("margin end", 32'h0, {31'h0, marginBusy});
		if (marginBusy !== 1'b0)
			report_and_stop();
		@(posedge mclk) wpPin <= 1'b0;
		step(4);
	endtask
	task automatic sc_wpreg;
		wr(twg_pkg::IDX_WPREG, 32'h80);
		wr(twg_pkg::IDX_PAGE, 32'h1);
		rd("page wr80", twg_pkg::IDX_PAGE, 32'h0);
		st("cml wr", 0, 1'b1);
		wr(twg_pkg::IDX_WPREG, 32'h40);
		wr(twg_pkg::IDX_PAGE, 32'h1);
		rd("page wr40", twg_pkg::IDX_PAGE, 32'h1);
		wr(twg_pkg::IDX_PWM, 32'h2);
		rd("pwm wr40", twg_pkg::IDX_PWM, 32'h0);
		wr(twg_pkg::IDX_WPREG, 32'h0);
		wr(twg_pkg::IDX_PAGE, 32'h0);
		wr(twg_pkg::IDX_CLRF, 32'h0);
	endtask
	task automatic sc_current;
		@(posedge mclk);
		meas[0] <= '{16'd1000, 16'sd125, 8'd128};
		meas[1] <= '{16'd1000, 16'sd25, 8'd128};
		step(4);
		rd("iout0", twg_pkg::IDX_IOUT, 32'(iexp(1000, 125)));
		rd("tpeak0", twg_pkg::IDX_TPEAK, 32'd125);
		wr(twg_pkg::IDX_PWM, 32'h12);
		wr(twg_pkg::IDX_PAGE, 32'h1);
		wr(twg_pkg::IDX_PWM, 32'h2);
		rd("iout1", twg_pkg::IDX_IOUT, 32'(iexp(1000, 125)));
		rd("temp1", twg_pkg::IDX_TEMP, 32'd25);
		rd("iin1", twg_pkg::IDX_IIN, 32'(((128 * iexp(1000, 125)) >> 7) + 61));
		st("fcm", 3, 1'b1);
		bus(twg_pkg::IDX_IINOFS, 1'b1, 32'h100, 4'h3);
		step(4);
		rd("iin1 ofs", twg_pkg::IDX_IIN, 32'(((128 * iexp(1000, 125)) >> 7) + 256));
		wr(twg_pkg::IDX_PWM, 32'h0);
		wr(twg_pkg::IDX_PAGE, 32'h0);
		wr(twg_pkg::IDX_PWM, 32'h0);
		wr(twg_pkg::IDX_PAGE, 32'h1);
		rd("iout1 own", twg_pkg::IDX_IOUT, 32'd1000);
		wr(twg_pkg::IDX_PAGE, 32'h0);
	endtask
	task automatic sc_vin;
		@(posedge mclk) vinSample <= 16'd1000;
		step(4);
		@(posedge mclk) vinSample <= 16'd500;
		step(4);
		rd("vin", twg_pkg::IDX_VIN, 32'd500);
		rd("vpeak", twg_pkg::IDX_VPEAK, 32'd1000);
		wr(twg_pkg::IDX_CLRPK, 32'h0);
		step(4);
		rd("vpeak clr", twg_pkg::IDX_VPEAK, 32'd500);
	endtask
	task automatic sc_eeprom;
		eeN = 0;
		wr(twg_pkg::IDX_UNLOCK, 32'h2b);
		wr(twg_pkg::IDX_STORE, 32'h0);
		step(3);
		chk("store", 32'd1, 32'(eeN));
		chk("store part", 32'h0, {31'h0, eeFl});
		@(posedge mclk) dieTemp <= 16'sd131;
		step(3);
		wr(twg_pkg::IDX_UNLOCK, 32'h2b);
		wr(twg_pkg::IDX_STORE, 32'h0);
		step(3);
		chk("store hot", 32'd1, 32'(eeN));
		st("cml hot", 0, 1'b1);
		@(posedge mclk) dieTemp <= 16'sd127;
		step(3);
		st("ee hyst", 1, 1'b1);
		@(posedge mclk) dieTemp <= 16'sd124;
		step(3);
		st("ee free", 1, 1'b0);
		@(posedge mclk) faultLogReq <= 1'b1;
		@(posedge mclk) faultLogReq <= 1'b0;
		step(4);
		chk("flog", 32'd2, 32'(eeN));
		chk("flog part", 32'h1, {31'h0, eeFl});
		wr(twg_pkg::IDX_CLRF, 32'h0);
	endtask
	task automatic sc_link;
		@(posedge mclk) runIn <= 2'b10;
		step(40);
		st("lowf", 2, 1'b1);
		psN = 0;
		@(posedge mclk) syncEn <= 1'b1;
		step(300);
		st("lowf clr", 2, 1'b0);
		chk("phase", 32'h1, 32'(psN > 0));
		chk("ramp0", 32'h0, {24'h0, ramp[0]});
		chk("ramp1", 32'h1, 32'(ramp[1] > 8'h0));
		// own heartbeat pull-down stands half of each 32-cycle period
		n = 0;
		repeat (32)
		begin
			step(1);
			n += int'(hbOe);
		end
		chk("hb duty", 32'd16, 32'(n));
	endtask
	// reset, then the scenarios
	initial
	begin
		{rst_n, cyc, stb, we, faultLogReq, wpPin, syncEn} = '0;
		{adr, sel, dIn, runIn, vinSample} = '0;
		meas = '0;
		dieTemp = 16'sd40;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		for (n = 0; n < 200 && initBusy !== 1'b0; n++)
			step(1);
		if (initBusy !== 1'b0)
		begin
			badCount++;
			report_and_stop();
		end
		sc_defaults();
		sc_pin();
		sc_wpreg();
		sc_current();
		sc_vin();
		sc_eeprom();
		sc_link();
		report_and_stop();
	end
endmodule
